// file: hw/ddsl_fifo.sv
// Purpose: Frame word FIFO held in flip-flops
// Assumes: DEPTH is a power of two
// Notes: Full and empty follow the occupancy count
`default_nettype none

module ddsl_fifo #(
   parameter int unsigned WIDTH = 24,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic  clock,
   input  wire logic  sys_rst,
   ddsl_stream_if.snk fill,
   ddsl_stream_if.src drain
);
   localparam int unsigned AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_check
      $error("ddsl_fifo: DEPTH must be a power of two above one");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 count;
   } ddsl_fifo_s;

   ddsl_fifo_s st;
   ddsl_fifo_s next_st;
   logic       push;
   logic       pop;

   assign fill.ready  = (st.count != (AW + 1)'(DEPTH));
   assign drain.valid = (st.count != '0);
   assign drain.data  = st.mem[st.rd];
   assign push        = fill.valid && fill.ready;
   assign pop         = drain.valid && drain.ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = fill.data;
         next_st.wr         = st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = st.rd + 1'b1;
      end
      if (push && !pop) begin
         next_st.count = st.count + 1'b1;
      end else if (pop && !push) begin
         next_st.count = st.count - 1'b1;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : ddsl_fifo

`default_nettype wire

// file: hw/ddsl_link_rx.sv
// Purpose: Serial shift logic on the link clock
// Assumes: Serial clock idles between frames
// Notes: Completed word is announced by a toggle
`default_nettype none

module ddsl_link_rx (
   input  wire logic        serial_clock,
   input  wire logic        frame_sync_n,
   input  wire logic        serial_data,
   input  wire logic        sys_rst,
   output logic [23:0]      frame_word,
   output logic             frame_toggle
);
   typedef struct packed {
      logic [ddsl_pkg::COUNT_W-1:0] count;
      logic [22:0]                  shift;
   } ddsl_shift_s;

   typedef struct packed {
      logic [23:0] word;
      logic        toggle;
   } ddsl_hold_s;

   ddsl_shift_s sh;
   ddsl_shift_s next_sh;
   ddsl_hold_s  hd;
   ddsl_hold_s  next_hd;
   logic        frame_clear;

   // Select high holds the shifter cleared, so a rise aborts a partial frame
   assign frame_clear = frame_sync_n | sys_rst;

   always_comb begin
      next_sh = sh;
      next_hd = hd;
      if (sh.count != ddsl_pkg::FULL_COUNT) begin
         next_sh.shift = {sh.shift[21:0], serial_data};
         next_sh.count = sh.count + 1'b1;
      end
      if (sh.count == ddsl_pkg::LAST_BIT) begin
         next_hd.word   = {sh.shift, serial_data};
         next_hd.toggle = ~hd.toggle;
      end
   end

   always_ff @(negedge serial_clock or posedge frame_clear) begin
      if (frame_clear) begin
         sh <= '0;
      end else begin
         sh <= next_sh;
      end
   end

   always_ff @(negedge serial_clock or posedge sys_rst) begin
      if (sys_rst) begin
         hd <= '0;
      end else begin
         hd <= next_hd;
      end
   end

   assign frame_word   = hd.word;
   assign frame_toggle = hd.toggle;
endmodule : ddsl_link_rx

`default_nettype wire

// file: hw/ddsl_loader.sv
// Purpose: Dual channel converter serial loader top
// Assumes: Host keeps link clock within its limit
// Notes: Commands queue in a FIFO before they are applied
`default_nettype none

module ddsl_loader (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        frame_sync_n,
   input  wire logic        serial_clock,
   input  wire logic        serial_data,
   input  wire logic        apply_stall,
   output logic [15:0]      channel_a_output,
   output logic [15:0]      channel_b_output,
   output logic             channel_a_powered_down,
   output logic             channel_b_powered_down,
   output logic             cmd_applied,
   output logic             word_lost
);
   typedef struct packed {
      logic        tog_meta;
      logic        tog_sync;
      logic        tog_seen;
      logic        pending;
      logic [23:0] pend_word;
      logic [1:0][15:0] in_buf;
      logic [1:0][15:0] out_code;
      logic [1:0]  pd;
      logic        applied;
      logic        lost;
   } ddsl_top_s;

   ddsl_top_s   st;
   ddsl_top_s   next_st;
   logic [23:0] link_word;
   logic        link_toggle;
   logic [23:0] cmd;
   logic        sel;
   logic        take;

   ddsl_stream_if #(.WIDTH(ddsl_pkg::FRAME_BITS)) push_if ();
   ddsl_stream_if #(.WIDTH(ddsl_pkg::FRAME_BITS)) pop_if ();

   ddsl_link_rx u_link (
      .serial_clock (serial_clock),
      .frame_sync_n (frame_sync_n),
      .serial_data  (serial_data),
      .sys_rst      (sys_rst),
      .frame_word   (link_word),
      .frame_toggle (link_toggle)
   );

   ddsl_fifo #(
      .WIDTH (ddsl_pkg::FRAME_BITS),
      .DEPTH (ddsl_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock   (clock),
      .sys_rst (sys_rst),
      .fill    (push_if),
      .drain   (pop_if)
   );

   assign push_if.valid = st.pending;
   assign push_if.data  = st.pend_word;
   assign pop_if.ready  = ~apply_stall;
   assign cmd           = pop_if.data;
   assign sel           = cmd[ddsl_pkg::SEL_POS];
   assign take          = pop_if.valid && pop_if.ready;

   always_comb begin
      next_st          = st;
      next_st.tog_meta = link_toggle;
      next_st.tog_sync = st.tog_meta;
      next_st.applied  = 1'b0;
      next_st.lost     = 1'b0;
      if (push_if.valid && push_if.ready) begin
         next_st.pending = 1'b0;
      end
      // Word is stable on the link side once its toggle is seen here
      if (st.tog_sync != st.tog_seen) begin
         next_st.tog_seen  = st.tog_sync;
         next_st.pend_word = link_word;
         next_st.lost      = st.pending && !push_if.ready;
         next_st.pending   = 1'b1;
      end
      // Apply one complete frame
      if (take) begin
         next_st.applied = 1'b1;
         if (cmd[ddsl_pkg::PD_CMD_POS]) begin
            next_st.pd[sel] = cmd[ddsl_pkg::PD_ON_POS];
         end else begin
            next_st.in_buf[sel] = cmd[ddsl_pkg::DATA_BITS-1:0];
            if (cmd[ddsl_pkg::LOAD_SEL_POS]) begin
               next_st.out_code[sel] = cmd[ddsl_pkg::DATA_BITS-1:0];
            end
            if (cmd[ddsl_pkg::LOAD_ALL_POS]) begin
               next_st.out_code = next_st.in_buf;
            end
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign channel_a_output       = st.out_code[0];
   assign channel_b_output       = st.out_code[1];
   assign channel_a_powered_down = st.pd[0];
   assign channel_b_powered_down = st.pd[1];
   assign cmd_applied            = st.applied;
   assign word_lost              = st.lost;
endmodule : ddsl_loader

`default_nettype wire

// file: hw/ddsl_pkg.sv
// Purpose: Shared constants for the dual converter serial loader
// Assumes: Frame is 24 bits, most significant bit first
`default_nettype none

package ddsl_pkg;
   localparam int unsigned FRAME_BITS   = 24;
   localparam int unsigned CTRL_BITS    = 8;
   localparam int unsigned DATA_BITS    = 16;
   localparam int unsigned COUNT_W      = 5;
   localparam logic [4:0]  LAST_BIT     = 5'h17;
   localparam logic [4:0]  FULL_COUNT   = 5'h18;
   localparam int unsigned FIFO_DEPTH   = 8;
   localparam int unsigned SCLK_MAX_MHZ = 30;
   localparam int unsigned CLOCK_MHZ    = 100;
   // Control byte fields, bit positions within the 24-bit frame
   localparam int unsigned CTRL_LSB     = 16;
   localparam int unsigned SEL_POS      = 16;
   localparam int unsigned LOAD_SEL_POS = 17;
   localparam int unsigned LOAD_ALL_POS = 18;
   localparam int unsigned PD_CMD_POS   = 19;
   localparam int unsigned PD_ON_POS    = 20;
   localparam logic [15:0] ZERO_SCALE   = 16'h0000;
endpackage : ddsl_pkg

`default_nettype wire

// file: hw/ddsl_stream_if.sv
// Purpose: Valid and ready word carrier between loader parts
// Assumes: One clock for both ends
// Notes: Word moves when valid and ready are both high
`default_nettype none

interface ddsl_stream_if #(
   parameter int unsigned WIDTH = 24
);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ddsl_stream_if

`default_nettype wire

// file: verification/ddsl_host_model.sv
// Purpose: Host side of the three-wire link
// Assumes: Link clock idles high outside frames
// Notes: Fewer than 24 bits makes an abort
`default_nettype none

module ddsl_host_model (
   output var logic frame_sync_n,
   output var logic serial_clock,
   output var logic serial_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      frame_sync_n = 1'b1;
      serial_clock = 1'b1;
      serial_data  = 1'b0;
   end
   task automatic send(input logic [23:0] word, input int bits);
      frame_sync_n = 1'b0;
      for (int i = 23; i > 23 - bits; i--) begin
         serial_data = word[i];
         #6 serial_clock = 1'b0;
         #6 serial_clock = 1'b1;
      end
      #6 frame_sync_n = 1'b1;
      serial_data = ~serial_data;
      #12;
   endtask : send
endmodule : ddsl_host_model

`default_nettype wire

// file: verification/ddsl_loader_checker.sv
// Purpose: Port assertions for the serial loader
// Assumes: Outputs move only with cmd_applied
// Notes: Bound to ddsl_loader
`default_nettype none

module ddsl_loader_checker (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        apply_stall,
   input wire logic [15:0] channel_a_output,
   input wire logic [15:0] channel_b_output,
   input wire logic        channel_a_powered_down,
   input wire logic        channel_b_powered_down,
   input wire logic        cmd_applied,
   input wire logic        word_lost
);
   timeunit 1ns;
   timeprecision 1ps;
   logic seen;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) seen <= 1'b0;
      else seen <= seen | cmd_applied;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_code_a_hold: assert property (!cmd_applied |-> $stable(channel_a_output))
      else $error("code A moved");
   a_code_b_hold: assert property (!cmd_applied |-> $stable(channel_b_output))
      else $error("code B moved");
   a_pd_a_hold: assert property (!cmd_applied |-> $stable(channel_a_powered_down))
      else $error("power A moved");
   a_pd_b_hold: assert property (!cmd_applied |-> $stable(channel_b_powered_down))
      else $error("power B moved");
   a_reset_zero: assert property (!seen && !cmd_applied |->
      channel_a_output == 16'h0000 && channel_b_output == 16'h0000)
      else $error("codes not zero");
   a_stall_holds: assert property ($past(apply_stall) && $past(apply_stall, 2) |->
      !cmd_applied)
      else $error("applied while stalled");
   a_lost_pulse: assert property (word_lost |=> !word_lost)
      else $error("lost pulse long");
   a_pd_keep_code: assert property ($changed(channel_a_powered_down) |->
      $stable(channel_a_output))
      else $error("power changed code");
   cover property (cmd_applied && channel_a_powered_down);
   cover property (word_lost);
   cover property (cmd_applied [*2]);
endmodule : ddsl_loader_checker

bind ddsl_loader ddsl_loader_checker chk_u (.clock, .sys_rst, .apply_stall,
   .channel_a_output, .channel_b_output, .channel_a_powered_down,
   .channel_b_powered_down, .cmd_applied, .word_lost);

`default_nettype wire

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the serial loader
// Assumes: Host model drives the link
// Notes: LFSR words mixed with fixed cases
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, sys_rst, apply_stall;
   logic        frame_sync_n, serial_clock, serial_data;
   logic [15:0] channel_a_output, channel_b_output;
   logic        channel_a_powered_down, channel_b_powered_down;
   logic        cmd_applied, word_lost;
   logic [15:0] buf_a, buf_b, out_a, out_b;
   logic        pd_a, pd_b;
   logic [31:0] seed;
   int          bad_count = 0, check_count = 0, applied = 0, lost = 0, cycles = 0, a0;
   logic [23:0] fixed [9] = '{24'h02ABCD, 24'h031234, 24'h005555, 24'h01AAAA,
      24'h04FFFF, 24'h180000, 24'h190000, 24'h080000, 24'h090000};

   ddsl_host_model host_u (.frame_sync_n, .serial_clock, .serial_data);
   ddsl_loader dut_u (.clock, .sys_rst, .frame_sync_n, .serial_clock, .serial_data,
      .apply_stall, .channel_a_output, .channel_b_output, .channel_a_powered_down,
      .channel_b_powered_down, .cmd_applied, .word_lost);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      applied <= applied + int'(cmd_applied === 1'b1);
      lost <= lost + int'(word_lost === 1'b1);
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         final_report;
      end
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         $display("MISMATCH %s exp %h got %h", n, e, g);
         bad_count++;
      end
   endtask : check
   task automatic check_all;
      check("chan_a", out_a, channel_a_output);
      check("chan_b", out_b, channel_b_output);
      check("pd_a", {15'h0000, pd_a}, {15'h0000, channel_a_powered_down});
      check("pd_b", {15'h0000, pd_b}, {15'h0000, channel_b_powered_down});
   endtask : check_all
   task automatic predict(input logic [23:0] w);
      if (w[ddsl_pkg::PD_CMD_POS]) begin
         if (w[ddsl_pkg::SEL_POS]) pd_b = w[ddsl_pkg::PD_ON_POS];
         else pd_a = w[ddsl_pkg::PD_ON_POS];
      end else begin
         if (w[ddsl_pkg::SEL_POS]) buf_b = w[15:0];
         else buf_a = w[15:0];
         if (w[ddsl_pkg::LOAD_ALL_POS]) {out_a, out_b} = {buf_a, buf_b};
         else if (w[ddsl_pkg::LOAD_SEL_POS] && w[ddsl_pkg::SEL_POS]) out_b = buf_b;
         else if (w[ddsl_pkg::LOAD_SEL_POS]) out_a = buf_a;
      end
   endtask : predict
   task automatic run(input logic [23:0] w);
      int s;
      s = applied;
      host_u.send(w, 24);
      predict(w);
      for (int k = 0; k < 20 && applied == s; k++) @(negedge clock);
      check("applied", 16'(s + 1), 16'(applied));
      check_all;
   endtask : run
   task final_report;
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   initial begin
      sys_rst = 1'b1;
      apply_stall = 1'b0;
      seed = 32'hC60C;
      {buf_a, buf_b, out_a, out_b, pd_a, pd_b} = '0;
      repeat (16) @(negedge clock);
      sys_rst = 1'b0;
      check_all;
      foreach (fixed[i]) run(fixed[i]);
      for (int i = 0; i < 16; i++) begin
         seed = lfsr_next(seed);
         run(seed[19] ? {seed[23:19], 2'b00, seed[16:0]} : seed[23:0]);
      end
      a0 = applied;
      host_u.send(24'h06FFFF, 23);
      repeat (20) @(negedge clock);
      check("abort", 16'(a0), 16'(applied));
      check_all;
      run(24'h021357);
      apply_stall = 1'b1;
      a0 = applied;
      for (int i = 1; i <= 10; i++) host_u.send({8'h02, 16'(i)}, 24);
      repeat (10) @(negedge clock);
      check("stalled", out_a, channel_a_output);
      apply_stall = 1'b0;
      repeat (30) @(negedge clock);
      check("lost", 16'h0001, 16'(lost));
      check("drained", 16'(a0 + 9), 16'(applied));
      out_a = 16'h000A;
      check_all;
      final_report;
   end
endmodule : tb_top

`default_nettype wire
